/* File: pkg/btbc_defs.vh */
`ifndef BTBC_DEFS_VH
`define BTBC_DEFS_VH
// opcode prefixes
`define BTBC_PFX_INVERT     4'h7
`define BTBC_PFX_BOV_HI     4'he
`define BTBC_PFX_BOV_LO     4'h4
`define BTBC_PFX_BZ         8'he0
`define BTBC_PFX_CALL1      7'h76
`define BTBC_PFX_CALL2      4'hf
// indexed literal offset limit
`define BTBC_ILO_LIMIT      8'h5f
// status flag positions
`define BTBC_FLAG_Z         2
`define BTBC_FLAG_OV        3
// call return offset in bytes
`define BTBC_CALL_RET       21'h000004
// phase one-hot codes
`define BTBC_Q1             4'h1
`define BTBC_Q2             4'h2
`define BTBC_Q3             4'h4
`define BTBC_Q4             4'h8
`endif

/* File: logic/btbc_exec.v */
`timescale 1ns/1ps
// Overview of operation
// - toggle only selected bit, flags unchanged
// - access flag picks access bank or bank
// - extended set, low addresses use indexed offset
// - overflow branch only when overflow set
// - zero branch only when zero set
// - target is pc plus twice signed offset
// - taken two cycles, not taken one
// - pc written Q4, then a flush cycle
// - call is two words with prefixes
// - shadow flag copies acc, flags, bank
// - call literal full 20 bits, flags untouched
`include "btbc_defs.vh"
module btbc_exec (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire [3:0]  phase_i,        // one-hot q1..q4 from the core
	input  wire [15:0] instr_i,        // current instruction word
	input  wire [15:0] instr2_i,       // following program word
	input  wire [20:0] pc_i,           // already incremented pc
	input  wire [7:0]  status_i,       // core status register
	input  wire [7:0]  accumulator_i,  // core accumulator
	input  wire [3:0]  bank_select_reg_i,
	input  wire        ext_set_en_i,   // extended instruction set enabled
	input  wire [11:0] ilo_base_i,     // index pointer for literal offset mode
	input  wire [7:0]  mem_rdata_i,    // data memory read data
	output reg  [11:0] mem_addr_o,
	output reg         mem_rd_o,
	output reg         mem_wr_o,
	output reg  [7:0]  mem_wdata_o,
	output reg         pc_wr_o,
	output reg  [20:0] pc_wdata_o,
	output reg         stack_push_o,
	output reg  [20:0] stack_top_o,
	output reg         shadow_wr_o,
	output reg  [7:0]  accumulator_shadow_o,
	output reg  [7:0]  flags_shadow_o,
	output reg  [3:0]  bank_select_shadow_o,
	output reg         flush_o,        // next cycle executes as no-operation
	output reg         busy_o          // second cycle of a two-cycle instruction
);

	// one-hot execution states
	localparam ST_IDLE  = 3'b001;
	localparam ST_EXEC  = 3'b010;
	localparam ST_FLUSH = 3'b100;
	// idle and exec behave the same; exec only marks that a q1 was seen
	// flush covers the whole second instruction cycle of a taken branch or a call
	// while in flush every decode is ignored, so a prefetched word cannot act
	// the phase input is trusted to step q1..q4 with no gaps
	// a phase code that is not one-hot falls to the default branch and does nothing
	// limitation: a phase sequence that starts in mid-cycle is not recovered
	// the first q1 after reset starts a clean cycle
	// trade-off: no phase counter of our own, so the core keeps full control
	// of when an instruction cycle begins

	reg [2:0]  state;        // first or second (flush) cycle
	reg [7:0]  work_byte;    // byte captured in q2
	reg [20:0] branch_tgt;   // computed in q3

	// resolve a file address; access bank low half maps below 0x060, high half to sfr page
	// bank mode: bank select forms the upper nibble
	// extended mode: only low access-bank addresses move to the pointer window
	// the pointer sum wraps inside 12 bits, which the core must keep in range
	// the same decode serves every byte-oriented operation, hence a function
	function [11:0] resolve_addr;
		input [7:0]  f;
		input        a;
		input [3:0]  bank;
		input        ext;
		input [11:0] base;
		begin
			if (a)
				resolve_addr = {bank, f};
			else if (ext && (f <= `BTBC_ILO_LIMIT))
				resolve_addr = base + {4'h0, f};
			else if (f <= `BTBC_ILO_LIMIT)
				resolve_addr = {4'h0, f};
			else
				resolve_addr = {4'hf, f};
		end
	endfunction

	// decode strobes
	// instr_i must stay stable across all four phases of its cycle
	// the call decode also checks the second word, so a stray first word
	// without its partner never pushes the stack
	// flag bits are read as levels; the core holds them through the cycle
	wire is_invert = (instr_i[15:12] == `BTBC_PFX_INVERT);
	wire is_bov    = (instr_i[15:12] == `BTBC_PFX_BOV_HI) && (instr_i[11:8] == `BTBC_PFX_BOV_LO);
	wire is_bz     = (instr_i[15:8] == `BTBC_PFX_BZ);
	wire is_call   = (instr_i[15:9] == `BTBC_PFX_CALL1) && (instr2_i[15:12] == `BTBC_PFX_CALL2);
	wire ov_set    = status_i[`BTBC_FLAG_OV];
	wire z_set     = status_i[`BTBC_FLAG_Z];
	wire take      = (is_bov && ov_set) || (is_bz && z_set);
	wire [11:0] f_addr = resolve_addr(instr_i[7:0], instr_i[8], bank_select_reg_i, ext_set_en_i, ilo_base_i);
	// sign extended offset doubled
	wire [20:0] offs2  = {{12{instr_i[7]}}, instr_i[7:0], 1'b0};

	// main sequencer; status is never written, so flags stay untouched
	// every output is a register, so each answer appears one edge after
	// the phase that asks for it
	// q1 decodes and addresses, q2 reads, q3 processes, q4 writes
	// strobes fall back to zero on every edge, so none can stick high
	// the branch target is formed every q3 outside the flush cycle and only used when taken
	// that costs a little power but keeps the q4 path short
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state                <= ST_IDLE;
			work_byte            <= 8'h00;
			branch_tgt           <= 21'h000000;
			mem_addr_o           <= 12'h000;
			mem_rd_o             <= 1'b0;
			mem_wr_o             <= 1'b0;
			mem_wdata_o          <= 8'h00;
			pc_wr_o              <= 1'b0;
			pc_wdata_o           <= 21'h000000;
			stack_push_o         <= 1'b0;
			stack_top_o          <= 21'h000000;
			shadow_wr_o          <= 1'b0;
			accumulator_shadow_o <= 8'h00;
			flags_shadow_o       <= 8'h00;
			bank_select_shadow_o <= 4'h0;
			flush_o              <= 1'b0;
			busy_o               <= 1'b0;
		end else begin
			// strobes are one-cycle pulses by default
			mem_rd_o     <= 1'b0;
			mem_wr_o     <= 1'b0;
			pc_wr_o      <= 1'b0;
			stack_push_o <= 1'b0;
			shadow_wr_o  <= 1'b0;
			case (state)
			ST_IDLE, ST_EXEC: begin
				case (phase_i)
				`BTBC_Q1: begin
					state  <= ST_EXEC;
					busy_o <= 1'b0;
					if (is_invert) begin
						mem_addr_o <= f_addr;
						mem_rd_o   <= 1'b1;
					end
				end
				`BTBC_Q2: begin
					// read data must be valid in q2 for the toggle
					// the memory answers within the same cycle as the read strobe
					// the return address is pushed before the pc is rewritten in q4
					if (is_invert)
						work_byte <= mem_rdata_i;
					if (is_call) begin
						stack_top_o  <= pc_i + `BTBC_CALL_RET;
						stack_push_o <= 1'b1;
					end
				end
				`BTBC_Q3: begin
					if (is_invert)
						mem_wdata_o <= work_byte ^ (8'h01 << instr_i[11:9]);
					branch_tgt <= pc_i + offs2;
					if (is_call && instr_i[8]) begin
						accumulator_shadow_o <= accumulator_i;
						flags_shadow_o       <= status_i;
						bank_select_shadow_o <= bank_select_reg_i;
						shadow_wr_o          <= 1'b1;
					end
				end
				`BTBC_Q4: begin
					// writes land here; a taken branch or a call also opens the flush
					// a not-taken branch leaves the pc to the core's own increment
					if (is_invert)
						mem_wr_o <= 1'b1;
					if (take) begin
						pc_wdata_o <= branch_tgt;
						pc_wr_o    <= 1'b1;
						flush_o    <= 1'b1;
						busy_o     <= 1'b1;
						state      <= ST_FLUSH;
					end else if (is_call) begin
						pc_wdata_o <= {instr2_i[11:0], instr_i[7:0], 1'b0};
						pc_wr_o    <= 1'b1;
						flush_o    <= 1'b1;
						busy_o     <= 1'b1;
						state      <= ST_FLUSH;
					end
				end
				default: ;
				endcase
			end
			ST_FLUSH: begin
				// whole cycle is a no-operation
				// busy and flush end together so the next q1 is a normal cycle
				if (phase_i == `BTBC_Q4) begin
					flush_o <= 1'b0;
					busy_o  <= 1'b0;
					state   <= ST_IDLE;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

endmodule

/* File: verif/btbc_mem_model.sv */
`timescale 1ns/1ps
module btbc_mem_model (
	input  wire       clk_i,
	input  wire [11:0] addr_i,
	input  wire       rd_i,
	input  wire       wr_i,
	input  wire [7:0] wdata_i,
	output wire [7:0] rdata_o
);
	logic [7:0] mem [0:4095]; // data bytes
	logic [7:0] junk = 8'h00; // steps by 8'h3b each cycle so read data off the strobe keeps changing
	// read data holds only while the read strobe stands
	assign rdata_o = rd_i ? mem[addr_i] : junk;
	// write on the strobe
	always @(posedge clk_i) begin
		junk <= junk + 8'h3b;
		if (wr_i)
			mem[addr_i] <= wdata_i;
	end
endmodule

/* File: verif/btbc_exec_sva.sv */
`timescale 1ns/1ps
module btbc_exec_sva (
	input wire clk_i, rst_n_i, mem_rd_o, mem_wr_o, pc_wr_o, stack_push_o, shadow_wr_o, flush_o,
	input wire [3:0]  phase_i,
	input wire [15:0] instr_i, instr2_i,
	input wire [20:0] pc_i, pc_wdata_o, stack_top_o,
	input wire [7:0]  mem_rdata_i, mem_wdata_o, status_i
);
	wire status_i_z = status_i[2];
	wire status_i_ov = status_i[3];
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// decodes, gated so a flushed cycle counts as nothing
	wire tg = instr_i[15:12] == 4'h7 && !flush_o;
	wire br = (instr_i[15:8] == 8'he4 || instr_i[15:8] == 8'he0) && !flush_o;
	wire go = instr_i[10] ? status_i_ov : status_i_z;
	wire cl = instr_i[15:9] == 7'h76 && !flush_o;
	wire [20:0] tgt = pc_i + {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
	AST_TG_RD: assert property (phase_i == 4'h1 && tg |=> mem_rd_o) else $error("no read");
	AST_TG_WR: assert property (phase_i == 4'h8 && tg |=> mem_wr_o) else $error("no write");
	AST_TG_DAT: assert property ($rose(mem_wr_o) |->
		mem_wdata_o == ($past(mem_rdata_i, 3) ^ (8'h1 << $past(instr_i[11:9])))) else $error("bad toggle");
	AST_BR_GO: assert property (phase_i == 4'h8 && br && go |=> pc_wr_o && pc_wdata_o == $past(tgt))
		else $error("bad branch");
	AST_BR_NO: assert property (phase_i == 4'h8 && br && !go |=> !pc_wr_o && !flush_o) else $error("bad skip");
	AST_FLUSH: assert property ($rose(flush_o) |-> flush_o [*4] ##1 !flush_o) else $error("bad flush");
	AST_PUSH: assert property (phase_i == 4'h2 && cl |=> stack_push_o && stack_top_o == $past(pc_i) + 21'h4)
		else $error("bad push");
	AST_SHADOW: assert property (phase_i == 4'h4 && cl |=> shadow_wr_o == $past(instr_i[8])) else $error("shadow");
	AST_CALL_PC: assert property (phase_i == 4'h8 && cl |=>
		pc_wr_o && pc_wdata_o == {$past(instr2_i[11:0]), $past(instr_i[7:0]), 1'b0}) else $error("call pc");
	cover property (phase_i == 4'h8 && br && go);
	cover property (phase_i == 4'h8 && cl && instr_i[8]);
	cover property ($rose(mem_wr_o));
endmodule
bind btbc_exec btbc_exec_sva u_btbc_exec_sva (.*);

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
	logic clk_i = 0, rst_n_i = 0, ext_set_en_i = 1;
	logic [3:0] phase_i = 0, bank_select_reg_i = 4'h3, bank_select_shadow_o;
	logic [15:0] instr_i = 0, instr2_i = 0;
	logic [20:0] pc_i = 21'h1000, pc_wdata_o, stack_top_o;
	logic [7:0] status_i = 0, accumulator_i = 8'ha5, mem_rdata_i, mem_wdata_o, accumulator_shadow_o, flags_shadow_o;
	logic [11:0] ilo_base_i = 12'h200, mem_addr_o;
	logic mem_rd_o, mem_wr_o, pc_wr_o, stack_push_o, shadow_wr_o, flush_o, busy_o;
	int mismatches = 0, comparisons = 0, n_pc, n_push, n_sh, n_fl, n_bz;
	always #2.5 clk_i = ~clk_i;
	btbc_exec u_btbc_exec (.*);
	btbc_mem_model u_btbc_mem_model (.clk_i, .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
		.wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
	// tally of strobes within one operation
	always @(posedge clk_i) begin
		n_pc += pc_wr_o;
		n_push += stack_push_o;
		n_sh += shadow_wr_o;
		n_fl += flush_o;
		n_bz += busy_o;
	end
	task chk(input logic [20:0] seen, input logic [20:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// two instruction cycles; w3 stands in the second one
	task ex(input logic [15:0] w1, w2, w3);
		{n_pc, n_push, n_sh, n_fl, n_bz} = '0;
		for (int k = 0; k < 8; k++) begin
			@(negedge clk_i);
			phase_i = 4'h1 << k[1:0];
			instr_i = k < 4 ? w1 : w3;
			instr2_i = w2;
		end
		@(posedge clk_i);
		#1;
	endtask
	task t_toggle(input logic [15:0] w, input logic [11:0] a, input logic [7:0] v);
		u_btbc_mem_model.mem[a] = v;
		ex(w, 16'h0, 16'h0);
		chk(u_btbc_mem_model.mem[a], v ^ (8'h1 << w[11:9]));
		chk(n_bz, 0);
	endtask
	// a toggle placed in the flush cycle must be ignored
	task t_branch(input logic [15:0] w, input logic [7:0] st, input logic tk);
		logic [7:0] v;
		v = u_btbc_mem_model.mem[12'hf60];
		status_i = st;
		ex(w, 16'h0, tk ? 16'h7060 : 16'h0);
		chk(n_pc, tk);
		chk(n_fl, tk ? 4 : 0);
		chk(n_bz, tk ? 4 : 0);
		chk(u_btbc_mem_model.mem[12'hf60], v);
		if (tk)
			chk(pc_wdata_o, pc_i + {{12{w[7]}}, w[7:0], 1'b0});
	endtask
	task t_call(input logic s, input logic [19:0] k);
		status_i = 8'h1c;
		ex({7'h76, s, k[7:0]}, {4'hf, k[19:8]}, 16'h0);
		chk(stack_top_o, pc_i + 21'h4);
		chk(pc_wdata_o, {k, 1'b0});
		chk(n_sh, s);
		chk(n_push, 1);
		chk(n_fl, 4);
		chk(n_bz, 4);
		if (s)
			chk({accumulator_shadow_o, flags_shadow_o, bank_select_shadow_o}, 21'h0a51c3);
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#2000;
		mismatches++;
		test_done;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		rst_n_i = 1;
		t_toggle(16'h7860, 12'hf60, 8'h75);
		t_toggle(16'h7e5f, 12'h25f, 8'h00);
		t_toggle(16'h7112, 12'h312, 8'hff);
		t_branch(16'he47f, 8'h08, 1);
		t_branch(16'he480, 8'h04, 0);
		t_branch(16'he080, 8'h04, 1);
		t_branch(16'he005, 8'h08, 0);
		t_call(1, 20'hfffff);
		t_call(0, 20'h00000);
		t_toggle(16'h7860, 12'hf60, 8'h75);
		test_done;
	end
endmodule
